//--- hw/tmr_top.sv
/*
 * Timer block: two 8051-style timer/counters (timer 0, timer 1) and a 16-bit
 * auto-reload timer 3 with prescaler and external clock for power-down use.
 * Assumes a single 50 MHz clock; external pins are asynchronous to it.
 */
`timescale 1ns/1ps
module tmr_top (
	input wire logic mclk,
	input wire logic arst_n,
	input wire tmr_pkg::tmr_bus_t bus,
	output logic [7:0] rdata,
	input wire logic [1:0] count_pin,
	input wire logic [1:0] external_interrupt_pin,
	input wire logic t3_clk_pin,
	input wire logic [1:0] irq_ack,
	output logic [1:0] timer_out,
	output logic [1:0] timer_irq,
	output logic timer3_irq
);
	import tmr_pkg::*;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [1:0] ovf_r;
	logic [1:0] run_r;
	logic [7:0] clk_out_r;
	logic [7:0] mode_r;
	logic [7:0] lo_r [2];
	logic [7:0] hi_r [2];
	logic [15:0] rld_r [2];
	logic [7:0] hold_hi_r [2];
	logic [7:0] t3_ctrl_r;
	logic [15:0] t3_cnt_r;
	logic [15:0] t3_rld_r;
	logic [7:0] t3_hold_hi_r;
	logic t3_ovf_r;
	logic t3_ie_r;
	logic pwr_down_r;
	logic [1:0] out_r;
	logic [3:0] div12_r;
	logic [7:0] ps_r;

	// Synchronisers and edge history
	logic [1:0] cnt_s1_r, cnt_s2_r, cnt_d_r;
	logic [1:0] gate_s1_r, gate_s2_r;
	logic t3c_s1_r, t3c_s2_r, t3c_d_r;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic is_wr(input tmr_bus_t b, input logic [3:0] off);
		is_wr = b.wr && (b.addr == off);
	endfunction : is_wr

	function automatic logic [1:0] mode_of(input logic [7:0] m, input int t);
		mode_of = (t == 0) ? m[B_T0_MODE +: 2] : m[B_T1_MODE +: 2];
	endfunction : mode_of

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	// Two flops per pin, then a history flop for falling edges on the count and timer 3 clock pins
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_s1_r <= 2'h0;
			cnt_s2_r <= 2'h0;
			cnt_d_r <= 2'h0;
			gate_s1_r <= 2'h0;
			gate_s2_r <= 2'h0;
			t3c_s1_r <= 1'b0;
			t3c_s2_r <= 1'b0;
			t3c_d_r <= 1'b0;
		end else begin
			cnt_s1_r <= count_pin;
			cnt_s2_r <= cnt_s1_r;
			cnt_d_r <= cnt_s2_r;
			gate_s1_r <= external_interrupt_pin;
			gate_s2_r <= gate_s1_r;
			t3c_s1_r <= t3_clk_pin;
			t3c_s2_r <= t3c_s1_r;
			t3c_d_r <= t3c_s2_r;
		end
	end

	// ---------------------------------------------------------------
	// Clock enables
	// ---------------------------------------------------------------
	// Divide-by-12 strobe for the timer 0 and 1 count ticks
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div12_r <= 4'h0;
		end else if (div12_r == SYS_DIV_LAST) begin
			div12_r <= 4'h0;
		end else begin
			div12_r <= div12_r + 4'h1;
		end
	end

	logic tick12;
	logic [1:0] tick_t;
	logic [1:0] ext_fall;
	logic [1:0] gate_ok;
	logic [1:0] inc_t;
	logic hi0_inc;
	assign tick12 = (div12_r == SYS_DIV_LAST);
	assign ext_fall = cnt_d_r & ~cnt_s2_r;
	assign tick_t[0] = clk_out_r[B_T0_SCALE] ? 1'b1 : tick12;
	assign tick_t[1] = clk_out_r[B_T1_SCALE] ? 1'b1 : tick12;
	assign gate_ok[0] = !mode_r[B_T0_GATE] || gate_s2_r[0];
	assign gate_ok[1] = !mode_r[B_T1_GATE] || gate_s2_r[1];
	// Timer 0 and 1 count events; timer 1 has no run bit of its own in split mode
	assign inc_t[0] = run_r[0] && gate_ok[0] &&
		(mode_r[B_T0_CNT] ? ext_fall[0] : tick_t[0]);
	assign inc_t[1] = ((mode_of(mode_r, 0) == TMR_M_SPLIT) ? 1'b1 : run_r[1]) &&
		(mode_of(mode_r, 1) != TMR_M_SPLIT) && gate_ok[1] &&
		(mode_r[B_T1_CNT] ? ext_fall[1] : tick_t[1]);
	assign hi0_inc = (mode_of(mode_r, 0) == TMR_M_SPLIT) && run_r[1] && tick_t[0];

	// ---------------------------------------------------------------
	// Timer 0 and 1 counters
	// ---------------------------------------------------------------
	logic [1:0] ovf_ev;
	logic hi0_ovf;
	assign hi0_ovf = hi0_inc && (hi_r[0] == 8'hff);

	for (genvar t = 0; t < 2; t++) begin : g_t
		logic [1:0] md;
		logic lo_wr, hi_wr, lo_full;
		assign md = mode_of(mode_r, t);
		assign lo_wr = is_wr(bus, (t == 0) ? OFF_T0_LOW : OFF_T1_LOW);
		assign hi_wr = is_wr(bus, (t == 0) ? OFF_T0_HIGH : OFF_T1_HIGH);
		assign lo_full = (lo_r[t] == 8'hff);
		// 16-bit modes wrap on both bytes full; 8-bit modes on low byte
		assign ovf_ev[t] = inc_t[t] && lo_full &&
			((md == TMR_M_RELOAD8 || md == TMR_M_SPLIT) || hi_r[t] == 8'hff);

		// Count bytes and reload word
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				lo_r[t] <= RST_BYTE;
				hi_r[t] <= RST_BYTE;
				rld_r[t] <= RST_WORD;
				hold_hi_r[t] <= RST_BYTE;
			end else begin
				if (hi_wr) begin
					hold_hi_r[t] <= bus.wdata;
				end
				if (md == TMR_M_RELOAD16) begin
					// High byte held until the low byte write commits the word
					if (lo_wr) begin
						rld_r[t] <= {hold_hi_r[t], bus.wdata};
					end
					if (lo_wr && !run_r[t]) begin
						lo_r[t] <= bus.wdata;
						hi_r[t] <= hold_hi_r[t];
					end else if (ovf_ev[t]) begin
						{hi_r[t], lo_r[t]} <= rld_r[t];
					end else if (inc_t[t]) begin
						{hi_r[t], lo_r[t]} <= {hi_r[t], lo_r[t]} + 16'h0001;
					end
				end else begin
					if (lo_wr) begin
						lo_r[t] <= bus.wdata;
					end else if (ovf_ev[t] && md == TMR_M_RELOAD8) begin
						lo_r[t] <= hi_r[t];
					end else if (inc_t[t]) begin
						lo_r[t] <= lo_r[t] + 8'h01;
					end
					if (hi_wr) begin
						hi_r[t] <= bus.wdata;
					end else if (t == 0 && md == TMR_M_SPLIT && hi0_inc) begin
						hi_r[t] <= hi_r[t] + 8'h01;
					end else if (md == TMR_M_PLAIN16 && inc_t[t] && lo_full) begin
						hi_r[t] <= hi_r[t] + 8'h01;
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Flags, run bits and output pins
	// ---------------------------------------------------------------
	logic [1:0] set_ovf;
	logic split0;
	assign split0 = (mode_of(mode_r, 0) == TMR_M_SPLIT);
	assign set_ovf[0] = ovf_ev[0];
	// Timer 1 cannot set its flag while timer 0 borrows it
	assign set_ovf[1] = split0 ? hi0_ovf : ovf_ev[1];

	// Run/flag register; set wins over clear
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ovf_r <= 2'h0;
			run_r <= 2'h0;
		end else begin
			if (is_wr(bus, OFF_RUN_FLAGS)) begin
				run_r <= {bus.wdata[B_T1_RUN], bus.wdata[B_T0_RUN]};
			end
			for (int t = 0; t < 2; t++) begin
				if (set_ovf[t]) begin
					ovf_r[t] <= 1'b1;
				end else if (irq_ack[t]) begin
					ovf_r[t] <= 1'b0;
				end else if (is_wr(bus, OFF_RUN_FLAGS)) begin
					ovf_r[t] <= bus.wdata[(t == 0) ? B_T0_OVF : B_T1_OVF];
				end
			end
		end
	end

	// Control registers; reserved clock/output bits masked
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			clk_out_r <= RST_BYTE;
			mode_r <= RST_BYTE;
		end else begin
			if (is_wr(bus, OFF_CLK_OUT)) begin
				clk_out_r <= bus.wdata & CLK_OUT_MASK;
			end
			if (is_wr(bus, OFF_MODE)) begin
				mode_r <= bus.wdata;
			end
		end
	end

	// Output pins toggle on overflow when enabled
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			out_r <= 2'h0;
		end else begin
			if (clk_out_r[B_T0_OUTEN] && ovf_ev[0]) begin
				out_r[0] <= ~out_r[0];
			end
			if (clk_out_r[B_T1_OUTEN] && ovf_ev[1]) begin
				out_r[1] <= ~out_r[1];
			end
		end
	end

	// ---------------------------------------------------------------
	// Timer 3
	// ---------------------------------------------------------------
	logic t3_run, t3_ext, t3_src, t3_tick, t3_ovf_ev, t3_lo_wr, t3_hi_wr;
	logic [7:0] ps_last;
	assign t3_run = t3_ctrl_r[B_T3_RUN];
	assign t3_ext = (t3_ctrl_r[B_T3_CLKS +: 2] == T3_CLK_EXT);
	// External clock keeps going in power-down, system clock does not
	assign t3_src = t3_ext ? (t3c_d_r && !t3c_s2_r) : !pwr_down_r;
	always_comb begin
		case (t3_ctrl_r[B_T3_PS +: 2])
			2'h0: ps_last = 8'h00;
			2'h1: ps_last = 8'h07;
			2'h2: ps_last = 8'h3f;
			default: ps_last = 8'hff;
		endcase
	end
	assign t3_tick = t3_run && t3_src && (ps_r == ps_last);
	assign t3_ovf_ev = t3_tick && (t3_cnt_r == 16'hffff);
	assign t3_lo_wr = is_wr(bus, OFF_T3_LOW);
	assign t3_hi_wr = is_wr(bus, OFF_T3_HIGH);

	// Prescaler counts source events while running
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ps_r <= 8'h00;
		end else if (!t3_run) begin
			ps_r <= 8'h00;
		end else if (t3_src) begin
			ps_r <= (ps_r == ps_last) ? 8'h00 : ps_r + 8'h01;
		end
	end

	// Counter and reload; high byte held until low byte write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			t3_cnt_r <= RST_WORD;
			t3_rld_r <= RST_WORD;
			t3_hold_hi_r <= RST_BYTE;
		end else begin
			if (t3_hi_wr) begin
				t3_hold_hi_r <= bus.wdata;
			end
			if (t3_lo_wr) begin
				t3_rld_r <= {t3_hold_hi_r, bus.wdata};
			end
			if (t3_lo_wr && !t3_run) begin
				t3_cnt_r <= {t3_hold_hi_r, bus.wdata};
			end else if (t3_ovf_ev) begin
				t3_cnt_r <= t3_rld_r;
			end else if (t3_tick) begin
				t3_cnt_r <= t3_cnt_r + 16'h0001;
			end
		end
	end

	// Control, flag, enable and power-down registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			t3_ctrl_r <= RST_BYTE;
			t3_ovf_r <= 1'b0;
			t3_ie_r <= 1'b0;
			pwr_down_r <= 1'b0;
		end else begin
			if (is_wr(bus, OFF_T3_CTRL)) begin
				t3_ctrl_r <= bus.wdata & T3_CTRL_MASK & ~(8'h01 << B_T3_OVF);
			end
			if (t3_ovf_ev) begin
				t3_ovf_r <= 1'b1;
			end else if (is_wr(bus, OFF_T3_CTRL)) begin
				t3_ovf_r <= bus.wdata[B_T3_OVF];
			end
			if (is_wr(bus, OFF_IRQ_EN2)) begin
				t3_ie_r <= bus.wdata[B_T3_IE];
			end
			if (is_wr(bus, OFF_PWR)) begin
				pwr_down_r <= bus.wdata[B_PWR_DOWN];
			end
		end
	end

	// ---------------------------------------------------------------
	// Read port, one cycle latency
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			if (bus.addr == OFF_RUN_FLAGS) begin
				rdata <= {ovf_r[1], run_r[1], ovf_r[0], run_r[0], 4'h0};
			end else if (bus.addr == OFF_CLK_OUT) begin
				rdata <= clk_out_r;
			end else if (bus.addr == OFF_MODE) begin
				rdata <= mode_r;
			end else if (bus.addr == OFF_T0_LOW) begin
				rdata <= lo_r[0];
			end else if (bus.addr == OFF_T0_HIGH) begin
				rdata <= hi_r[0];
			end else if (bus.addr == OFF_T1_LOW) begin
				rdata <= lo_r[1];
			end else if (bus.addr == OFF_T1_HIGH) begin
				rdata <= hi_r[1];
			end else if (bus.addr == OFF_T3_CTRL) begin
				rdata <= t3_ctrl_r | {t3_ovf_r, 7'h00};
			end else if (bus.addr == OFF_T3_LOW) begin
				rdata <= t3_cnt_r[7:0];
			end else if (bus.addr == OFF_T3_HIGH) begin
				rdata <= t3_cnt_r[15:8];
			end else if (bus.addr == OFF_IRQ_EN2) begin
				rdata <= {6'h00, t3_ie_r, 1'b0};
			end else if (bus.addr == OFF_PWR) begin
				rdata <= {7'h00, pwr_down_r};
			end else begin
				rdata <= 8'h00;
			end
		end
	end

	// Interrupt requests
	assign timer_irq = ovf_r;
	assign timer3_irq = t3_ovf_r && t3_ie_r;
	assign timer_out = out_r;
endmodule : tmr_top

//--- hw/tmr_pkg.sv
/*
 * Package for the timer block: register offsets, field positions, reset values,
 * mode encodings and the bus carrier struct.
 * Assumes an 8-bit register port, one register per byte address.
 */
package tmr_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] OFF_RUN_FLAGS = 4'h0;
	localparam logic [3:0] OFF_CLK_OUT = 4'h1;
	localparam logic [3:0] OFF_MODE = 4'h2;
	localparam logic [3:0] OFF_T0_LOW = 4'h3;
	localparam logic [3:0] OFF_T0_HIGH = 4'h4;
	localparam logic [3:0] OFF_T1_LOW = 4'h5;
	localparam logic [3:0] OFF_T1_HIGH = 4'h6;
	localparam logic [3:0] OFF_T3_CTRL = 4'h7;
	localparam logic [3:0] OFF_T3_LOW = 4'h8;
	localparam logic [3:0] OFF_T3_HIGH = 4'h9;
	localparam logic [3:0] OFF_IRQ_EN2 = 4'ha;
	localparam logic [3:0] OFF_PWR = 4'hb;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int B_T1_OVF = 7;
	localparam int B_T1_RUN = 6;
	localparam int B_T0_OVF = 5;
	localparam int B_T0_RUN = 4;
	localparam int B_T1_OUTEN = 5;
	localparam int B_T1_SCALE = 4;
	localparam int B_T0_OUTEN = 1;
	localparam int B_T0_SCALE = 0;
	localparam logic [7:0] CLK_OUT_MASK = 8'h33;
	localparam int B_T1_GATE = 7;
	localparam int B_T1_CNT = 6;
	localparam int B_T1_MODE = 4;
	localparam int B_T0_GATE = 3;
	localparam int B_T0_CNT = 2;
	localparam int B_T0_MODE = 0;
	localparam int B_T3_OVF = 7;
	localparam int B_T3_PDEN = 6;
	localparam int B_T3_PS = 4;
	localparam int B_T3_RUN = 2;
	localparam int B_T3_CLKS = 0;
	localparam logic [7:0] T3_CTRL_MASK = 8'hf7;
	localparam int B_T3_IE = 1;
	localparam int B_PWR_DOWN = 0;
	// ---------------------------------------------------------------
	// Reset values, timing
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam int SYS_DIV = 12;
	localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
	// ---------------------------------------------------------------
	// Encodings and carrier
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TMR_M_RELOAD16 = 2'h0,
		TMR_M_PLAIN16 = 2'h1,
		TMR_M_RELOAD8 = 2'h2,
		TMR_M_SPLIT = 2'h3
	} tmr_mode_t;
	localparam logic [1:0] T3_CLK_SYS = 2'h0;
	localparam logic [1:0] T3_CLK_EXT = 2'h1;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tmr_bus_t;
endpackage : tmr_pkg

//--- tb/tmr_chk_sva.sv
/*
 * Checker for the timer block: register readback, flag and output relations.
 * Assumes it is bound to tmr_top and sees only its ports.
 */
`timescale 1ns/1ps
module tmr_chk (
	input wire logic mclk,
	input wire logic arst_n,
	input wire tmr_pkg::tmr_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic [1:0] irq_ack,
	input wire logic [1:0] timer_out,
	input wire logic [1:0] timer_irq,
	input wire logic timer3_irq
);
	import tmr_pkg::*;
	logic [7:0] clk_r;
	logic [7:0] mode_r;
	logic ie_r;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// ---------------------------------------------------------------
	// Shadow copies of plain software registers
	// ---------------------------------------------------------------
	// Clock/output shadow
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) clk_r <= RST_BYTE;
		else if (bus.wr && bus.addr == OFF_CLK_OUT) clk_r <= bus.wdata;
	end
	// Mode shadow
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) mode_r <= RST_BYTE;
		else if (bus.wr && bus.addr == OFF_MODE) mode_r <= bus.wdata;
	end
	// Timer 3 interrupt enable shadow
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) ie_r <= 1'b0;
		else if (bus.wr && bus.addr == OFF_IRQ_EN2) ie_r <= bus.wdata[B_T3_IE];
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	property p_clk_rsvd;
		$past(bus.rd && bus.addr == OFF_CLK_OUT) |-> (rdata & ~CLK_OUT_MASK) == 8'h00;
	endproperty
	a_clk_rsvd: assert property (p_clk_rsvd)
	else $error("reserved clock/output bits read nonzero");
	property p_clk_val;
		$past(bus.rd && bus.addr == OFF_CLK_OUT) |-> rdata == (clk_r & CLK_OUT_MASK);
	endproperty
	a_clk_val: assert property (p_clk_val)
	else $error("clock/output readback differs from last write");
	property p_mode;
		$past(bus.rd && bus.addr == OFF_MODE) |-> rdata == mode_r;
	endproperty
	a_mode: assert property (p_mode)
	else $error("mode readback differs from last write");
	property p_flag0_fall;
		$fell(timer_irq[0]) |-> $past(irq_ack[0] || (bus.wr && bus.addr == OFF_RUN_FLAGS));
	endproperty
	a_flag0_fall: assert property (p_flag0_fall)
	else $error("timer 0 flag cleared without service or write");
	property p_flag1_fall;
		$fell(timer_irq[1]) |-> $past(irq_ack[1] || (bus.wr && bus.addr == OFF_RUN_FLAGS));
	endproperty
	a_flag1_fall: assert property (p_flag1_fall)
	else $error("timer 1 flag cleared without service or write");
	property p_out_toggle;
		$changed(timer_out[0]) |-> timer_irq[0] || $past(timer_irq[0]);
	endproperty
	a_out_toggle: assert property (p_out_toggle)
	else $error("timer 0 output moved without an overflow");
	property p_t3_irq_en;
		timer3_irq |-> ie_r;
	endproperty
	a_t3_irq_en: assert property (p_t3_irq_en)
	else $error("timer 3 interrupt while disabled");
	property p_run_rsvd;
		$past(bus.rd && bus.addr == OFF_RUN_FLAGS) |-> rdata[3:0] == 4'h0;
	endproperty
	a_run_rsvd: assert property (p_run_rsvd)
	else $error("reserved run/flag bits read nonzero");
endmodule : tmr_chk
bind tmr_top tmr_chk u_tmr_chk (.mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
	.irq_ack(irq_ack), .timer_out(timer_out), .timer_irq(timer_irq), .timer3_irq(timer3_irq));

//--- tb/tmr_pins_model.sv
/*
 * Far-side pin model: count and clock pulses on request, gate levels.
 * Assumes requests are one-cycle pulses spaced at least eight cycles.
 */
`timescale 1ns/1ps
module tmr_pins_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [2:0] preq,
	input wire logic [1:0] gate_lvl,
	output logic [1:0] count_pin,
	output logic [1:0] external_interrupt_pin,
	output logic t3_clk_pin
);
	logic [2:0] low_r [0:2];
	// Each request pulls its pin low for four cycles, one falling edge
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 3; i++) low_r[i] <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (preq[i]) low_r[i] <= 3'h4;
				else if (low_r[i] != 3'h0) low_r[i] <= low_r[i] - 3'h1;
			end
		end
	end
	// Count and timer 3 clock pins idle high between pulses; gate pins follow gate_lvl
	assign count_pin = {low_r[1] == 3'h0, low_r[0] == 3'h0};
	assign t3_clk_pin = low_r[2] == 3'h0;
	assign external_interrupt_pin = gate_lvl;
endmodule : tmr_pins_model

//--- tb/tb_top.sv
/*
 * Self-checking bench for the timer block with random and corner cases.
 * Assumes tmr_pkg, tmr_top, the pin model and the checker are compiled.
 */
`timescale 1ns/1ps
module tb_top;
	import tmr_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	tmr_bus_t bus_s = '0;
	logic [1:0] irq_ack = 2'b00;
	logic [2:0] preq = 3'b000;
	logic [1:0] gate_lvl = 2'b00;
	logic [7:0] rdata;
	logic [1:0] count_pin;
	logic [1:0] external_interrupt_pin;
	logic t3_clk_pin;
	logic [1:0] timer_out;
	logic [1:0] timer_irq;
	logic timer3_irq;
	logic [2:0] ev;
	logic [7:0] rv;
	logic [7:0] x;
	logic to0;
	int n_mismatch = 0;
	int comparisons = 0;
	int n;
	assign ev = {timer3_irq, timer_irq};
	// Clock
	always #10 mclk = ~mclk;
	tmr_top u_tmr_top (.mclk(mclk), .arst_n(arst_n), .bus(bus_s), .rdata(rdata),
		.count_pin(count_pin), .external_interrupt_pin(external_interrupt_pin),
		.t3_clk_pin(t3_clk_pin), .irq_ack(irq_ack), .timer_out(timer_out),
		.timer_irq(timer_irq), .timer3_irq(timer3_irq));
	tmr_pins_model u_tmr_pins_model (.mclk(mclk), .arst_n(arst_n), .preq(preq),
		.gate_lvl(gate_lvl), .count_pin(count_pin),
		.external_interrupt_pin(external_interrupt_pin), .t3_clk_pin(t3_clk_pin));
	// ---------------------------------------------------------------
	// Tasks and expectation functions
	// ---------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_s <= {a, d, 2'b10};
		@(posedge mclk);
		bus_s.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		bus_s <= {a, 8'h00, 2'b01};
		@(posedge mclk);
		bus_s.rd <= 1'b0;
		#1 rv = rdata;
	endtask : rd
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wait_ev(input int i, input int maxc);
		n = 0;
		while (n < maxc && ev[i] !== 1'b1) begin
			@(posedge mclk);
			#1 n++;
		end
	endtask : wait_ev
	task automatic ack(input int i);
		@(posedge mclk);
		irq_ack[i] <= 1'b1;
		@(posedge mclk);
		irq_ack[i] <= 1'b0;
		#1;
	endtask : ack
	task automatic pulse(input int i, input int k);
		repeat (k) begin
			@(posedge mclk);
			preq[i] <= 1'b1;
			@(posedge mclk);
			preq[i] <= 1'b0;
			repeat (10) @(posedge mclk);
		end
		#1;
	endtask : pulse
	function automatic int div_of(input int p);
		case (p)
			0: return 1;
			1: return 8;
			2: return 64;
			default: return 256;
		endcase
	endfunction : div_of
	function automatic logic in_win(input int c, input int d);
		return (c + 2 >= 3 * d) && (c <= 4 * d + 8);
	endfunction : in_win
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	// Watchdog
	initial begin
		#400000;
		n_mismatch++;
		end_of_test();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(6));
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		for (int a = 0; a < 16; a++) begin
			rd(4'(a));
			chk("reset read", rv, RST_BYTE);
		end
		repeat (6) begin
			x = 8'($urandom);
			wr(OFF_CLK_OUT, x);
			rd(OFF_CLK_OUT);
			chk("clk out", rv, x & CLK_OUT_MASK);
			wr(OFF_MODE, 8'h11);
			rd(OFF_MODE);
			chk("mode", rv, 8'h11);
			for (int a = 3; a < 7; a++) begin
				wr(4'(a), x);
				rd(4'(a));
				chk("count byte", rv, x);
			end
			x = 8'($urandom);
			wr(OFF_T3_HIGH, x);
			wr(OFF_T3_LOW, ~x);
			rd(OFF_T3_HIGH);
			chk("t3 high", rv, x);
			rd(OFF_T3_LOW);
			chk("t3 low", rv, ~x);
		end
		wr(OFF_IRQ_EN2, 8'h02);
		wr(OFF_T3_HIGH, 8'hff);
		wr(OFF_T3_LOW, 8'he0);
		wr(OFF_T3_CTRL, 8'h04);
		wr(OFF_T3_HIGH, 8'h12);
		wr(OFF_T3_LOW, 8'h34);
		rd(OFF_T3_HIGH);
		chk("t3 count kept", rv, 8'hff);
		wait_ev(2, 64);
		chk("t3 irq", 8'(timer3_irq), 8'h01);
		rd(OFF_T3_CTRL);
		chk("t3 ctrl", rv, 8'h84);
		wr(OFF_IRQ_EN2, 8'h00);
		chk("t3 masked", 8'(timer3_irq), 8'h00);
		wr(OFF_IRQ_EN2, 8'h02);
		wr(OFF_T3_CTRL, 8'h00);
		rd(OFF_T3_HIGH);
		chk("t3 reloaded", rv, 8'h12);
		for (int p = 0; p < 4; p++) begin
			wr(OFF_T3_CTRL, 8'h00);
			wr(OFF_T3_HIGH, 8'hff);
			wr(OFF_T3_LOW, 8'hfc);
			wr(OFF_T3_CTRL, 8'(8'h04 | (p << 4)));
			wait_ev(2, 1100);
			chk("t3 prescale", 8'(in_win(n, div_of(p))), 8'h01);
		end
		wr(OFF_T3_CTRL, 8'h00);
		wr(OFF_T3_HIGH, 8'hff);
		wr(OFF_T3_LOW, 8'hfc);
		wr(OFF_PWR, 8'h01);
		wr(OFF_T3_CTRL, 8'h04);
		wait_ev(2, 40);
		chk("t3 power-down sys", 8'(timer3_irq), 8'h00);
		wr(OFF_T3_CTRL, 8'h45);
		pulse(2, 6);
		chk("t3 power-down ext", 8'(timer3_irq), 8'h01);
		wr(OFF_PWR, 8'h00);
		wr(OFF_T3_CTRL, 8'h00);
		wr(OFF_MODE, 8'h01);
		wr(OFF_T0_HIGH, 8'hff);
		wr(OFF_T0_LOW, 8'hf0);
		wr(OFF_CLK_OUT, 8'h03);
		to0 = timer_out[0];
		wr(OFF_RUN_FLAGS, 8'h10);
		wait_ev(0, 40);
		chk("t0 flag", 8'(timer_irq[0]), 8'h01);
		chk("t0 out", 8'(timer_out[0]), {7'h00, ~to0});
		ack(0);
		chk("t0 ack", 8'(timer_irq[0]), 8'h00);
		wr(OFF_RUN_FLAGS, 8'h00);
		wr(OFF_CLK_OUT, 8'h00);
		wr(OFF_T0_HIGH, 8'hff);
		wr(OFF_T0_LOW, 8'hfe);
		to0 = timer_out[0];
		wr(OFF_RUN_FLAGS, 8'h10);
		wait_ev(0, 10);
		chk("t0 div early", 8'(timer_irq[0]), 8'h00);
		wait_ev(0, 40);
		chk("t0 div flag", 8'(timer_irq[0]), 8'h01);
		chk("t0 out off", 8'(timer_out[0]), 8'(to0));
		wr(OFF_RUN_FLAGS, 8'h00);
		wr(OFF_MODE, 8'h02);
		wr(OFF_CLK_OUT, 8'h01);
		wr(OFF_T0_HIGH, 8'hf0);
		wr(OFF_T0_LOW, 8'hfe);
		wr(OFF_RUN_FLAGS, 8'h10);
		wait_ev(0, 20);
		wr(OFF_RUN_FLAGS, 8'h00);
		rd(OFF_T0_HIGH);
		chk("t0 reload byte", rv, 8'hf0);
		rd(OFF_T0_LOW);
		chk("t0 low reloaded", rv & 8'hf0, 8'hf0);
		wr(OFF_MODE, 8'h05);
		wr(OFF_T0_HIGH, 8'hff);
		wr(OFF_T0_LOW, 8'hfd);
		wr(OFF_RUN_FLAGS, 8'h10);
		wait_ev(0, 30);
		chk("t0 ext idle", 8'(timer_irq[0]), 8'h00);
		pulse(0, 3);
		wait_ev(0, 10);
		chk("t0 ext count", 8'(timer_irq[0]), 8'h01);
		wr(OFF_RUN_FLAGS, 8'h00);
		wr(OFF_MODE, 8'h09);
		wr(OFF_T0_HIGH, 8'hff);
		wr(OFF_T0_LOW, 8'hf0);
		wr(OFF_RUN_FLAGS, 8'h10);
		wait_ev(0, 30);
		chk("t0 gate low", 8'(timer_irq[0]), 8'h00);
		@(posedge mclk);
		gate_lvl <= 2'b01;
		wait_ev(0, 40);
		chk("t0 gate high", 8'(timer_irq[0]), 8'h01);
		wr(OFF_RUN_FLAGS, 8'h00);
		wr(OFF_MODE, 8'h00);
		wr(OFF_CLK_OUT, 8'h30);
		wr(OFF_T1_HIGH, 8'hff);
		wr(OFF_T1_LOW, 8'hfe);
		to0 = timer_out[1];
		wr(OFF_RUN_FLAGS, 8'h40);
		wait_ev(1, 20);
		chk("t1 first", 8'(timer_irq[1]), 8'h01);
		chk("t1 out", 8'(timer_out[1]), {7'h00, ~to0});
		ack(1);
		wait_ev(1, 8);
		chk("t1 reload", 8'(timer_irq[1]), 8'h01);
		wr(OFF_MODE, 8'h30);
		wr(OFF_RUN_FLAGS, 8'h40);
		wait_ev(1, 20);
		chk("t1 mode 3", 8'(timer_irq[1]), 8'h00);
		wr(OFF_RUN_FLAGS, 8'h00);
		wr(OFF_MODE, 8'h03);
		wr(OFF_CLK_OUT, 8'h01);
		wr(OFF_T0_HIGH, 8'hfe);
		wr(OFF_T0_LOW, 8'h00);
		wr(OFF_RUN_FLAGS, 8'h40);
		wait_ev(1, 10);
		chk("split high", 8'(timer_irq[1]), 8'h01);
		chk("split low", 8'(timer_irq[0]), 8'h00);
		wr(OFF_RUN_FLAGS, 8'h00);
		end_of_test();
	end
endmodule : tb_top
